// >>> smc_pkg.sv
// constants and types for the sleep mode controller
package smc_pkg;
    localparam logic [3:0] SMC_MODE_NORMAL = 4'h0;
    localparam logic [3:0] SMC_MODE_PIN = 4'h1;
    localparam logic [3:0] SMC_MODE_CYCLIC = 4'h4;
    localparam logic [3:0] SMC_MODE_CYCLIC_PIN = 4'h5;
    localparam logic [3:0] SMC_MODE_SUPPORT = 4'h7;
    localparam logic [3:0] SMC_MODE_SYNC_CYCLIC = 4'h8;
    localparam int SMC_CLK_HZ = 50000000;
    localparam int SMC_POLL_MS = 100;
    localparam int SMC_POLL_CYCLES = SMC_CLK_HZ / 1000 * SMC_POLL_MS;
    localparam int SMC_TIMER_W = 32;
    localparam logic [SMC_TIMER_W-1:0] SMC_TIMER_ZERO = 32'h0;
    localparam logic [SMC_TIMER_W-1:0] SMC_TIMER_ONE = 32'h1;
    typedef enum logic [3:0] {
        SMC_AWAKE = 4'h1,
        SMC_DRAIN = 4'h2,
        SMC_ASLEEP = 4'h4,
        SMC_POLL = 4'h8
    } smc_state_e;
endpackage : smc_pkg

// >>> smc_sleep_ctrl.sv
// sleep mode controller: mode decode, sleep/wake timers, awake and cts outputs
// Overview of operation
// RULE_01: modes 1,4,5 are asynchronous sleep; modes 7,8 are synchronous sleep.
// RULE_02: after reset mode is normal (0) and the device never sleeps.
// RULE_03: normal mode relays coordinator sync messages, never originates, routes anytime. The code relays one only once already synced.
// RULE_04: pin sleep: request high finishes transmit/receive then sleeps.
// RULE_05: pin sleep: request low wakes the device.
// RULE_06: cyclic sleep: sleep the period, then wake briefly to poll.
// RULE_07: cyclic: data while awake extends awake time, else sleep at once.
// RULE_08: cyclic: awake indicator high while awake, low asleep.
// RULE_09: flow control on: cts low when awake and ready, high asleep.
// RULE_10: mode 5 wakes on period expiry or request falling edge.
// RULE_11: support mode syncs, never sleeps, answers joiners with sync anytime.
// RULE_12: support mode sends normal data only while network awake. The code does so only once synced; unsynced, it sends anytime.
// RULE_13: coordinator broadcasts one sync per wake start; every node repeats it. The code never sends one: wake starts occur only in modes 4 and 5.
// RULE_14: synchronized nodes adopt most recent sleep and wake times.
// RULE_15: host should make asynchronous sleepers non-routing nodes.
// RULE_16: awake in modes 4 or 5, poll the parent every 100 ms.
// RULE_17: sleep and wake are countdown timers; data reloads wake timer.
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int POLL_CYCLES = SMC_POLL_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // configuration
    input wire logic mode_load_in,
    input wire logic [3:0] sleep_mode_select_in,
    input wire logic timing_load_in,
    input wire logic [SMC_TIMER_W-1:0] sleep_period_in,
    input wire logic [SMC_TIMER_W-1:0] wake_extension_time_in,
    input wire logic flow_control_pin_config_in,
    input wire logic coordinator_in,
    // host pin and activity
    input wire logic host_sleep_request_pin_in,
    input wire logic serial_rx_in,
    input wire logic radio_rx_in,
    input wire logic busy_in,
    input wire logic serial_ready_in,
    // network sync events
    input wire logic sync_rx_in,
    input wire logic sync_origin_sleepy_in,
    input wire logic [SMC_TIMER_W-1:0] sync_sleep_period_in,
    input wire logic [SMC_TIMER_W-1:0] sync_wake_time_in,
    input wire logic join_request_in,
    input wire logic network_awake_in,
    input wire logic data_tx_req_in,
    // status and actions
    output logic [3:0] mode_out,
    output logic async_mode_out,
    output logic sync_mode_out,
    output logic low_power_out,
    output logic awake_out,
    output logic cts_n_out,
    output logic poll_out,
    output logic sync_tx_out,
    output logic data_tx_ok_out,
    output logic synced_out
);
    smc_state_e state_q;
    logic [3:0] mode_q;
    logic [SMC_TIMER_W-1:0] sleep_cfg_q, wake_cfg_q, timer_q, poll_cnt_q;
    logic req_q, synced_q, wake_start_q, poll_q, sync_tx_q, data_ok_q;
    logic is_async, is_sync, is_cyclic, data_in, req_fall;

    assign data_in = serial_rx_in | radio_rx_in;
    assign req_fall = req_q & ~host_sleep_request_pin_in;
    assign is_async = (mode_q == SMC_MODE_PIN) | is_cyclic; // RULE_01
    assign is_cyclic = (mode_q == SMC_MODE_CYCLIC) | (mode_q == SMC_MODE_CYCLIC_PIN);
    assign is_sync = (mode_q == SMC_MODE_SUPPORT) | (mode_q == SMC_MODE_SYNC_CYCLIC); // RULE_01

    // mode register, normal after reset
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= SMC_MODE_NORMAL; // RULE_02
        end else if (mode_load_in) begin
            mode_q <= sleep_mode_select_in;
        end
    end

    // latest configured times win, whether set locally or by sync
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_cfg_q <= SMC_TIMER_ONE;
            wake_cfg_q <= SMC_TIMER_ONE;
        end else if (timing_load_in) begin
            sleep_cfg_q <= sleep_period_in; // RULE_14
            wake_cfg_q <= wake_extension_time_in;
        end else if (sync_rx_in && sync_origin_sleepy_in) begin
            sleep_cfg_q <= sync_sleep_period_in; // RULE_14
            wake_cfg_q <= sync_wake_time_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_q <= 1'b0;
        end else begin
            req_q <= host_sleep_request_pin_in;
        end
    end

    // sleep state machine; timer counts sleep period or awake time
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= SMC_AWAKE;
            timer_q <= SMC_TIMER_ZERO;
            wake_start_q <= 1'b0;
        end else begin
            wake_start_q <= 1'b0;
            case (state_q)
                SMC_AWAKE: begin
                    if (mode_q == SMC_MODE_PIN && host_sleep_request_pin_in) begin
                        state_q <= SMC_DRAIN; // RULE_04
                    end else if (is_cyclic) begin
                        state_q <= SMC_POLL;
                        timer_q <= SMC_TIMER_ZERO;
                    end
                end
                SMC_DRAIN: begin
                    if (!host_sleep_request_pin_in) begin
                        state_q <= SMC_AWAKE; // RULE_05
                    end else if (!busy_in) begin
                        state_q <= SMC_ASLEEP; // RULE_04
                    end
                end
                SMC_ASLEEP: begin
                    if (mode_q == SMC_MODE_PIN) begin
                        if (!host_sleep_request_pin_in) begin
                            state_q <= SMC_AWAKE; // RULE_05
                        end
                    end else if (!is_cyclic) begin
                        state_q <= SMC_AWAKE; // never sleeps outside sleep modes
                    end else if (timer_q <= SMC_TIMER_ONE ||
                                 (mode_q == SMC_MODE_CYCLIC_PIN && req_fall)) begin
                        state_q <= SMC_POLL; // RULE_06 RULE_10
                        timer_q <= SMC_TIMER_ZERO;
                        wake_start_q <= 1'b1;
                    end else begin
                        timer_q <= timer_q - SMC_TIMER_ONE; // RULE_17
                    end
                end
                SMC_POLL: begin
                    if (!is_cyclic) begin
                        state_q <= SMC_AWAKE;
                    end else if (data_in) begin
                        timer_q <= wake_cfg_q; // RULE_07 RULE_17
                    end else if (busy_in) begin
                        timer_q <= timer_q; // finish current exchange first
                    end else if (timer_q <= SMC_TIMER_ONE) begin
                        state_q <= SMC_ASLEEP; // RULE_07
                        timer_q <= sleep_cfg_q;
                    end else begin
                        timer_q <= timer_q - SMC_TIMER_ONE; // RULE_17
                    end
                end
                default: begin
                    state_q <= SMC_AWAKE;
                end
            endcase
        end
    end

    // parent polls: one on wake, then every poll interval while awake in modes 4 and 5
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            poll_cnt_q <= SMC_TIMER_ZERO;
            poll_q <= 1'b0;
        end else if (state_q != SMC_POLL) begin
            poll_cnt_q <= SMC_TIMER_ZERO;
            poll_q <= 1'b0;
        end else if (poll_cnt_q == SMC_TIMER_ZERO) begin
            poll_cnt_q <= POLL_CYCLES[SMC_TIMER_W-1:0] - SMC_TIMER_ONE; // RULE_16
            poll_q <= 1'b1;
        end else begin
            poll_cnt_q <= poll_cnt_q - SMC_TIMER_ONE;
            poll_q <= 1'b0;
        end
    end

    // sync handling: normal and async modes relay only others' syncs; coordinator never sends, as wake_start_q rises only in modes 4 and 5
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            synced_q <= 1'b0;
            sync_tx_q <= 1'b0;
        end else begin
            if (sync_rx_in && sync_origin_sleepy_in) begin
                synced_q <= 1'b1;
            end
            if (mode_q == SMC_MODE_NORMAL || is_async) begin
                sync_tx_q <= synced_q && sync_rx_in && sync_origin_sleepy_in; // RULE_03 RULE_13
            end else begin
                sync_tx_q <= (sync_rx_in && sync_origin_sleepy_in) // RULE_13
                    || (coordinator_in && wake_start_q) // RULE_13
                    || (mode_q == SMC_MODE_SUPPORT && join_request_in); // RULE_11
            end
        end
    end

    // data gating: a synchronized support node waits for the network wake window
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_ok_q <= 1'b0;
        end else if (mode_q == SMC_MODE_SUPPORT && synced_q) begin
            data_ok_q <= data_tx_req_in && network_awake_in; // RULE_12
        end else begin
            data_ok_q <= data_tx_req_in && !low_power_out; // RULE_03
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_power_out <= 1'b0;
            awake_out <= 1'b1;
            cts_n_out <= 1'b0;
        end else begin
            low_power_out <= (state_q == SMC_ASLEEP); // RULE_02 RULE_11
            awake_out <= (state_q != SMC_ASLEEP); // RULE_08
            // cts stays low without flow control so the host is never blocked
            cts_n_out <= flow_control_pin_config_in &&
                ((state_q == SMC_ASLEEP) || !serial_ready_in); // RULE_09
        end
    end

    assign mode_out = mode_q;
    assign async_mode_out = is_async;
    assign sync_mode_out = is_sync;
    assign poll_out = poll_q;
    assign sync_tx_out = sync_tx_q;
    assign data_tx_ok_out = data_ok_q;
    assign synced_out = synced_q;
endmodule : smc_sleep_ctrl
`default_nettype wire

// >>> smc_sleep_ctrl_chk.sv
// port assertions for the sleep controller
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl_chk
    import smc_pkg::*;
(
    // watched ports
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic flow_control_pin_config_in,
    input wire logic host_sleep_request_pin_in,
    input wire logic busy_in,
    input wire logic sync_rx_in,
    input wire logic network_awake_in,
    input wire logic [3:0] mode_out,
    input wire logic async_mode_out,
    input wire logic sync_mode_out,
    input wire logic low_power_out,
    input wire logic awake_out,
    input wire logic cts_n_out,
    input wire logic poll_out,
    input wire logic sync_tx_out,
    input wire logic data_tx_ok_out,
    input wire logic synced_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    wire logic ea = mode_out inside {SMC_MODE_PIN, SMC_MODE_CYCLIC, SMC_MODE_CYCLIC_PIN};
    wire logic es = mode_out inside {SMC_MODE_SUPPORT, SMC_MODE_SYNC_CYCLIC};
    wire logic cyc = mode_out inside {SMC_MODE_CYCLIC, SMC_MODE_CYCLIC_PIN};
    wire logic m1 = mode_out == SMC_MODE_PIN;
    sequence s_pin_asleep;
        m1 && low_power_out;
    endsequence
    sequence s_req_low;
        !host_sleep_request_pin_in;
    endsequence
    a_mode_decode: assert property (async_mode_out == ea && sync_mode_out == es)
        else $error("mode decode wrong");
    a_normal_awake: assert property ((mode_out == SMC_MODE_NORMAL) [*3] |-> awake_out)
        else $error("normal mode asleep");
    a_no_origin: assert property ((mode_out == 4'h0 && !sync_rx_in) [*3] |-> !sync_tx_out)
        else $error("normal mode sent own sync");
    a_drain_busy: assert property ((m1 && busy_in) [*3] |-> !$rose(low_power_out))
        else $error("slept during transfer");
    a_pin_wake: assert property (s_pin_asleep ##0 s_req_low |-> ##[1:4] !low_power_out)
        else $error("pin low did not wake");
    a_awake_level: assert property (cyc |-> awake_out != low_power_out)
        else $error("awake flag wrong");
    a_cts_asleep: assert property (flow_control_pin_config_in && low_power_out |-> cts_n_out)
        else $error("cts asserted asleep");
    a_pin_edge: assert property ((mode_out == SMC_MODE_CYCLIC_PIN && low_power_out &&
        $fell(host_sleep_request_pin_in)) |-> ##[1:4] !low_power_out) else $error("edge no wake");
    a_support_on: assert property ((mode_out == SMC_MODE_SUPPORT) [*3] |-> !low_power_out)
        else $error("support mode slept");
    // only a synchronized support node knows when the network is awake
    a_data_gate: assert property ((mode_out == SMC_MODE_SUPPORT && synced_out &&
        !network_awake_in) [*2] |-> ##1 !data_tx_ok_out)
        else $error("data sent while network asleep");
    a_poll_mode: assert property (poll_out |-> cyc || $past(cyc))
        else $error("poll outside cyclic mode");
endmodule : smc_sleep_ctrl_chk
bind smc_sleep_ctrl smc_sleep_ctrl_chk u_chk (.clk_sys_in, .rst_n_in, .flow_control_pin_config_in,
    .host_sleep_request_pin_in, .busy_in, .sync_rx_in, .network_awake_in, .mode_out,
    .async_mode_out, .sync_mode_out, .low_power_out, .awake_out, .cts_n_out, .poll_out,
    .sync_tx_out, .data_tx_ok_out, .synced_out);
`default_nettype wire

// >>> smc_host_model.sv
// host side model driving the sleep request pin
`timescale 1ns/100ps
`default_nettype none
module smc_host_model (
    // clock, intent and slowness
    input wire logic clk_sys_in,
    input wire logic want_sleep_in,
    input wire logic [3:0] lag_in,
    // pin
    output logic host_sleep_request_pin_out
);
    logic [3:0] cnt_q;
    initial host_sleep_request_pin_out = 1'b0;
    initial cnt_q = 4'h0;
    // host keeps asynchronous sleepers non-routing: this model never routes
    // a slow host lets the pin trail its intent by lag plus one cycles
    always @(negedge clk_sys_in) begin
        if (want_sleep_in == host_sleep_request_pin_out) cnt_q <= 4'h0;
        else if (cnt_q >= lag_in) host_sleep_request_pin_out <= want_sleep_in;
        else cnt_q <= cnt_q + 4'h1;
    end
endmodule : smc_host_model
`default_nettype wire

// >>> smc_sleep_ctrl_tb_top.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl_tb_top
    import smc_pkg::*;
;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, mload = 1'b0, tload = 1'b0, want = 1'b0;
    logic busy = 1'b0, srx = 1'b0, e;
    logic [3:0] msel = 4'h0, lag = 4'h0;
    logic [7:0] nz = 8'h00;
    logic [31:0] sp = 32'h10, wx = 32'h8, rs = 32'h0052B307;
    logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h7, 4'h8};
    wire logic req, asy, syn, lp, aw, cts_n, poll, stx, dok, syncd;
    wire logic [3:0] mode;
    int mismatches = 0, total_checks = 0, n, pc;
    int q_async[$] = '{1, 4, 5};
    always #10 clk_sys_in = ~clk_sys_in;
    smc_host_model host (.clk_sys_in, .want_sleep_in(want), .lag_in(lag),
        .host_sleep_request_pin_out(req));
    smc_sleep_ctrl #(.POLL_CYCLES(20)) DUT (.clk_sys_in, .rst_n_in, .mode_load_in(mload),
        .sleep_mode_select_in(msel), .timing_load_in(tload), .sleep_period_in(sp),
        .wake_extension_time_in(wx), .flow_control_pin_config_in(1'b1),
        .coordinator_in(nz[0]), .host_sleep_request_pin_in(req), .serial_rx_in(srx),
        .radio_rx_in(nz[6]), .busy_in(busy), .serial_ready_in(~nz[7]), .sync_rx_in(nz[1]),
        .sync_origin_sleepy_in(nz[2]), .sync_sleep_period_in(sp), .sync_wake_time_in(wx),
        .join_request_in(nz[3]), .network_awake_in(nz[4]), .data_tx_req_in(nz[5]),
        .mode_out(mode), .async_mode_out(asy), .sync_mode_out(syn), .low_power_out(lp),
        .awake_out(aw), .cts_n_out(cts_n), .poll_out(poll), .sync_tx_out(stx),
        .data_tx_ok_out(dok), .synced_out(syncd));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // bounded wait on the sleep level, then compare
    task automatic wait_lp(input logic v, input int lim, input string what);
        n = 0;
        while (lp !== v && n < lim) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(32'(lp), 32'(v), what);
    endtask : wait_lp
    task automatic setm(input logic [3:0] m);
        msel = m;
        mload = 1'b1;
        @(negedge clk_sys_in);
        mload = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask : setm
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #(20 * 5000);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk(32'(mode), 32'h0, "reset mode");
        chk(32'({aw, lp, cts_n}), 32'h4, "reset levels");
        foreach (codes[i]) begin
            setm(codes[i]);
            e = 1'b0;
            foreach (q_async[j]) e |= (q_async[j] == int'(codes[i]));
            chk(32'(mode), 32'(codes[i]), "mode load");
            chk(32'({asy, syn}), 32'({e, codes[i] >= 4'h7}), "mode class");
        end
        $display("test modes done");
        // random network traffic must never put these two modes to sleep
        foreach (codes[i]) if (codes[i] == 4'h0 || codes[i] == 4'h7) begin
            setm(codes[i]);
            repeat (40) begin
                rs = xs(rs);
                nz = rs[7:0];
                @(negedge clk_sys_in);
                chk(32'(lp), 32'h0, "awake mode slept");
            end
        end
        nz = 8'h00;
        $display("test never sleep done");
        setm(4'h1);
        busy = 1'b1;
        want = 1'b1;
        lag = 4'h3;
        repeat (10) @(negedge clk_sys_in);
        chk(32'(lp), 32'h0, "slept while busy");
        busy = 1'b0;
        wait_lp(1'b1, 10, "no pin sleep");
        chk(32'(cts_n), 32'h1, "cts asleep");
        want = 1'b0;
        wait_lp(1'b0, 20, "no pin wake");
        chk(32'(cts_n), 32'h0, "cts awake");
        $display("test pin sleep done");
        rs = xs(rs);
        sp = 32'h8 + 32'(rs[3:0]);
        tload = 1'b1;
        @(negedge clk_sys_in);
        tload = 1'b0;
        setm(4'h4);
        wait_lp(1'b1, 30, "no sleep without data");
        chk(32'(aw), 32'h0, "awake flag asleep");
        srx = 1'b1;
        wait_lp(1'b0, int'(sp) + 8, "no timed wake");
        pc = 0;
        repeat (45) begin
            @(negedge clk_sys_in);
            pc += int'(poll);
            chk(32'(lp), 32'h0, "data did not extend");
        end
        chk(32'(pc >= 2), 32'h1, "poll count");
        chk(32'(aw), 32'h1, "awake flag awake");
        srx = 1'b0;
        wait_lp(1'b1, int'(wx) + 8, "no sleep after extension");
        $display("test cyclic done");
        sp = 32'd2000;
        tload = 1'b1;
        want = 1'b1;
        @(negedge clk_sys_in);
        tload = 1'b0;
        setm(4'h5);
        wait_lp(1'b1, 40, "mode 5 no sleep");
        // let any short sleep left from mode 4 run out into the long one
        repeat (30) @(negedge clk_sys_in);
        chk(32'(lp), 32'h1, "mode 5 long sleep");
        want = 1'b0;
        lag = 4'h2;
        wait_lp(1'b0, 12, "no early pin wake");
        $display("test pin wake done");
        setm(4'h7);
        nz = 8'h06;
        @(negedge clk_sys_in);
        chk(32'(syncd), 32'h1, "not synced");
        chk(32'(stx), 32'h1, "sync not repeated");
        nz = 8'h08;
        @(negedge clk_sys_in);
        chk(32'(stx), 32'h1, "joiner not answered");
        nz = 8'h20;
        @(negedge clk_sys_in);
        chk(32'(dok), 32'h0, "data while network asleep");
        nz = 8'h30;
        @(negedge clk_sys_in);
        chk(32'(dok), 32'h1, "data blocked network awake");
        nz = 8'h00;
        setm(4'h0);
        nz = 8'h03;
        @(negedge clk_sys_in);
        chk(32'(stx), 32'h0, "normal originated sync");
        nz = 8'h06;
        @(negedge clk_sys_in);
        chk(32'(stx), 32'h1, "normal did not relay");
        nz = 8'h20;
        @(negedge clk_sys_in);
        chk(32'(dok), 32'h1, "normal data blocked");
        nz = 8'h00;
        $display("test sync done");
        stop_test();
    end
endmodule : smc_sleep_ctrl_tb_top
`default_nettype wire
